// ### core/pes_pkg.sv
// Package with event codes and source bundles for the event qualifier.
package pes_pkg;
    // Event code width and the selectable event codes.
    localparam int EVW = 8;
    localparam logic [7:0] EV_RD_STALL = 8'h1a;
    localparam logic [7:0] EV_WR_EM_STALL = 8'h1b;
    localparam logic [7:0] EV_LOCKED = 8'h1c;
    localparam logic [7:0] EV_IO_CYCLE = 8'h1d;
    localparam logic [7:0] EV_NC_READ = 8'h1e;
    localparam logic [7:0] EV_ADDR_ILK = 8'h1f;
    localparam logic [7:0] EV_RSVD_0 = 8'h20;
    localparam logic [7:0] EV_RSVD_1 = 8'h21;
    localparam logic [7:0] EV_FLOAT_OPS = 8'h22;
    localparam logic [7:0] EV_DBG_MATCH_0 = 8'h23;
    localparam logic [7:0] EV_DBG_MATCH_1 = 8'h24;
    // Least increment width that holds the largest per-clock count.
    localparam int INC_W_MIN = 3;
    // Width of a register number in the pipeline.
    localparam int REG_W = 3;
    // Reset values.
    localparam logic RST_PEND = 1'b0;
    localparam logic [3:0] RST_PINS = 4'h0;

    // One bus cycle start seen by the bus unit.
    typedef struct packed {
        logic start;            // First clock of a bus cycle.
        logic locked;           // Locked cycle.
        logic write;            // Write cycle, else read.
        logic io;               // Cycle to I/O space.
        logic noncacheable;     // Noncacheable memory cycle.
        logic split_cycle_flag; // Locked sequence is split in two.
        logic bus_backoff;      // Current cycle aborted by back-off.
    } pes_bus_t;

    // Address generation and execute stage register usage, two pipes.
    typedef struct packed {
        logic [1:0] exe_wr_valid;       // Execute stage writes a register.
        logic [1:0][2:0] exe_wr_reg;    // Register written in execute.
        logic [1:0] agen_base_valid;    // Address gen stage uses a base.
        logic [1:0][2:0] agen_base_reg; // Base register in address gen.
        logic [1:0] agen_idx_valid;     // Address gen stage uses an index.
        logic [1:0][2:0] agen_idx_reg;  // Index register in address gen.
    } pes_agen_t;

    // Floating-point unit activity in one clock.
    typedef struct packed {
        logic [1:0] arith_ops; // Internal adds or multiplies this clock.
        logic excl_fault;      // Zero divide, neg root, special or stack.
        logic int_mul;         // Integer multiply executed by the unit.
    } pes_fpu_t;

    // Raw breakpoint comparator outputs for four debug registers.
    typedef struct packed {
        logic [3:0] match_u;  // Match on an instruction or data in pipe one.
        logic [3:0] match_v;  // Match in pipe two.
        logic [3:0] is_code;  // Register holds a code breakpoint.
        logic [3:0] enabled;  // Breakpoint enabled by software.
    } pes_bp_t;
endpackage

// ### core/pes_event_select.sv
// Event qualifier for performance events 1ah to 24h.
`timescale 1ns/1ps

module pes_event_select #(
    parameter int INC_W = 3
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] event_code,
    input wire logic rd_stall,
    input wire logic wr_em_stall,
    input wire pes_pkg::pes_bus_t bus,
    input wire pes_pkg::pes_agen_t agen,
    input wire pes_pkg::pes_fpu_t fpu,
    input wire pes_pkg::pes_bp_t bp,
    output logic [INC_W-1:0] increment,
    output logic [3:0] breakpoint_pins
);

    // The widest count, four unit operations, needs three bits; two split halves need only two.
    if (INC_W < pes_pkg::INC_W_MIN) begin : g_inc_w_check
        $error("INC_W too small for the per-clock count.");
    end

    // Back-off bookkeeping: remembers that the next bus start is a restart.
    logic restart_pend_reg;
    logic restart_pend_next;
    // Registered increment and breakpoint pin state.
    logic [INC_W-1:0] inc_reg;
    logic [INC_W-1:0] inc_next;
    logic [3:0] pins_reg;
    logic [3:0] pins_next;
    // Qualified per-event occurrence counts for this clock.
    logic [2:0] cnt_locked;
    logic cnt_io;
    logic cnt_nc;
    logic [1:0] cnt_ilk;
    logic [2:0] cnt_flt;
    logic fresh_start;

    // Restart tracking: an aborted cycle is retried, and the retry must not count again.
    always_comb begin
        // A start clears the pending mark; a back-off in the same clock sets it and wins.
        restart_pend_next = restart_pend_reg;
        if (bus.start) begin
            restart_pend_next = 1'b0;
        end
        if (bus.bus_backoff) begin
            restart_pend_next = 1'b1;
        end
    end

    // Restart tracking register.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            restart_pend_reg <= pes_pkg::RST_PEND;
        end else begin
            restart_pend_reg <= restart_pend_next;
        end
    end

    // Event qualification and selection for the selected event code.
    always_comb begin
        fresh_start = bus.start & ~restart_pend_reg;
        cnt_locked = 3'h0;
        if (fresh_start && bus.locked && !bus.write) begin
            cnt_locked = bus.split_cycle_flag ? 3'h2 : 3'h1;
        end
        cnt_io = fresh_start & bus.io;
        cnt_nc = fresh_start & ~bus.io & ~bus.write & bus.noncacheable;
        cnt_ilk = 2'h0;
        for (int a = 0; a < 2; a++) begin
            for (int e = 0; e < 2; e++) begin
                if (agen.exe_wr_valid[e] &&
                    ((agen.agen_base_valid[a] &&
                      agen.agen_base_reg[a] == agen.exe_wr_reg[e]) ||
                     (agen.agen_idx_valid[a] &&
                      agen.agen_idx_reg[a] == agen.exe_wr_reg[e]))) begin
                    cnt_ilk[a] = 1'b1;
                end
            end
        end
        cnt_flt = 3'h0;
        if (!fpu.excl_fault) begin
            cnt_flt = {1'b0, fpu.arith_ops};
        end
        cnt_flt = cnt_flt + {2'h0, fpu.int_mul};
        // Breakpoint pins follow the qualified matches.
        for (int i = 0; i < 4; i++) begin
            pins_next[i] = bp.match_u[i] |
                (bp.match_v[i] & ~(bp.is_code[i] & ~bp.enabled[i]));
        end
        // Selection of the increment by event code.
        inc_next = '0;
        unique case (event_code)
            pes_pkg::EV_RD_STALL: inc_next = INC_W'(rd_stall);
            pes_pkg::EV_WR_EM_STALL: inc_next = INC_W'(wr_em_stall);
            pes_pkg::EV_LOCKED: inc_next = INC_W'(cnt_locked);
            pes_pkg::EV_IO_CYCLE: inc_next = INC_W'(cnt_io);
            pes_pkg::EV_NC_READ: inc_next = INC_W'(cnt_nc);
            pes_pkg::EV_ADDR_ILK: inc_next = INC_W'({1'b0, cnt_ilk[0]}) +
                INC_W'({1'b0, cnt_ilk[1]});
            pes_pkg::EV_FLOAT_OPS: inc_next = INC_W'(cnt_flt);
            pes_pkg::EV_DBG_MATCH_0: inc_next = INC_W'(pins_next[0]);
            pes_pkg::EV_DBG_MATCH_1: inc_next = INC_W'(pins_next[1]);
            default: inc_next = '0;
        endcase
    end

    // Output registers: the increment and the pins appear one clock after the event.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            inc_reg <= '0;
            pins_reg <= pes_pkg::RST_PINS;
        end else begin
            inc_reg <= inc_next;
            pins_reg <= pins_next;
        end
    end

    // Outputs come straight from flip-flops.
    assign increment = inc_reg;
    assign breakpoint_pins = pins_reg;

    // Read stall clocks give exactly one per clock.
    AST_RD_STALL: assert property (@(posedge core_clk) disable iff (rst)
        (event_code == pes_pkg::EV_RD_STALL) |=> (increment == INC_W'($past(rd_stall))))
        else $error("Read stall increment wrong.");

    // Write stall count follows its source.
    AST_WR_STALL: assert property (@(posedge core_clk) disable iff (rst)
        (event_code == pes_pkg::EV_WR_EM_STALL && wr_em_stall) |=> (increment == 1))
        else $error("Write stall not counted.");

    // A fresh locked read counts one or two.
    AST_LOCKED: assert property (@(posedge core_clk) disable iff (rst)
        (event_code == pes_pkg::EV_LOCKED && bus.start && !restart_pend_reg && bus.locked &&
         !bus.write && !bus.bus_backoff) |=> (increment == ($past(bus.split_cycle_flag) ? 2 : 1)))
        else $error("Locked read count wrong.");

    // A locked write half never counts.
    AST_LOCK_WR: assert property (@(posedge core_clk) disable iff (rst)
        (event_code == pes_pkg::EV_LOCKED && bus.write) |=> (increment == 0))
        else $error("Locked write half counted.");

    // After a back-off the next start does not count as I/O.
    AST_RESTART: assert property (@(posedge core_clk) disable iff (rst)
        (bus.bus_backoff && !bus.start) ##1 (event_code == pes_pkg::EV_IO_CYCLE && bus.start)
        |=> (increment == 0))
        else $error("Restarted cycle recounted.");

    // A fresh I/O start counts one.
    AST_IO: assert property (@(posedge core_clk) disable iff (rst)
        (event_code == pes_pkg::EV_IO_CYCLE && bus.start && bus.io && !restart_pend_reg)
        |=> (increment == 1))
        else $error("I/O cycle not counted.");

    // I/O reads never count as noncacheable reads.
    AST_NC_IO: assert property (@(posedge core_clk) disable iff (rst)
        (event_code == pes_pkg::EV_NC_READ && bus.io) |=> (increment == 0))
        else $error("I/O read counted as noncacheable.");

    // The interlock count never exceeds two.
    AST_ILK: assert property (@(posedge core_clk) disable iff (rst)
        (event_code == pes_pkg::EV_ADDR_ILK) |=> (increment <= 2))
        else $error("Interlock count above two.");

    // A listed exception leaves only the integer multiply count.
    AST_FLT_EXC: assert property (@(posedge core_clk) disable iff (rst)
        (event_code == pes_pkg::EV_FLOAT_OPS && fpu.excl_fault)
        |=> (increment == INC_W'($past(fpu.int_mul))))
        else $error("Faulting float op counted.");

    // Without a fault every internal operation is counted.
    AST_FLT_OPS: assert property (@(posedge core_clk) disable iff (rst)
        (event_code == pes_pkg::EV_FLOAT_OPS && !fpu.excl_fault && !fpu.int_mul)
        |=> (increment == INC_W'($past(fpu.arith_ops))))
        else $error("Float op count wrong.");

    // A disabled pipe-two code match alone does not reach the pins.
    AST_BP_V: assert property (@(posedge core_clk) disable iff (rst)
        (bp.match_v[0] && !bp.match_u[0] && bp.is_code[0] && !bp.enabled[0])
        |=> !breakpoint_pins[0])
        else $error("Unchecked pipe-two match counted.");

    // Match event one equals pin one.
    AST_BP_PIN: assert property (@(posedge core_clk) disable iff (rst)
        ($past(event_code) == pes_pkg::EV_DBG_MATCH_1)
        |-> (increment == INC_W'(breakpoint_pins[1])))
        else $error("Match count differs from pin.");

    // A pipe-one match counts even when disabled.
    AST_BP_U: assert property (@(posedge core_clk) disable iff (rst)
        (event_code == pes_pkg::EV_DBG_MATCH_0 && bp.match_u[0]) |=> (increment == 1))
        else $error("Breakpoint match not counted.");

    // Reserved codes add nothing.
    AST_RSVD: assert property (@(posedge core_clk) disable iff (rst)
        (event_code == pes_pkg::EV_RSVD_0 || event_code == pes_pkg::EV_RSVD_1)
        |=> (increment == 0))
        else $error("Reserved code counted.");

    // A clock without a write stall adds nothing.
    AST_WR_IDLE: assert property (@(posedge core_clk) disable iff (rst)
        (event_code == pes_pkg::EV_WR_EM_STALL && !wr_em_stall) |=> (increment == 0))
        else $error("Write stall counted without a stall.");

    // An unlocked bus cycle never counts as a locked one.
    AST_LOCK_UNLK: assert property (@(posedge core_clk) disable iff (rst)
        (event_code == pes_pkg::EV_LOCKED && !bus.locked) |=> (increment == 0))
        else $error("Unlocked cycle counted as locked.");

    // A restarted locked cycle is not counted again.
    AST_LOCK_RESTART: assert property (@(posedge core_clk) disable iff (rst)
        (event_code == pes_pkg::EV_LOCKED && restart_pend_reg) |=> (increment == 0))
        else $error("Restarted locked cycle recounted.");

    // A back-off always leaves the restart mark set, even with a start in the same clock.
    AST_MARK_SET: assert property (@(posedge core_clk) disable iff (rst)
        bus.bus_backoff |=> restart_pend_reg)
        else $error("Back-off did not mark the restart.");

    // Clocks without a bus start add no I/O count.
    AST_IO_IDLE: assert property (@(posedge core_clk) disable iff (rst)
        (event_code == pes_pkg::EV_IO_CYCLE && !bus.start) |=> (increment == 0))
        else $error("I/O counted without a bus start.");

    // A fresh noncacheable memory read counts one.
    AST_NC_READ: assert property (@(posedge core_clk) disable iff (rst)
        (event_code == pes_pkg::EV_NC_READ && bus.start && !restart_pend_reg && !bus.io &&
         !bus.write && bus.noncacheable) |=> (increment == 1))
        else $error("Noncacheable read not counted.");

    // A restarted noncacheable read is not counted again.
    AST_NC_RESTART: assert property (@(posedge core_clk) disable iff (rst)
        (event_code == pes_pkg::EV_NC_READ && restart_pend_reg) |=> (increment == 0))
        else $error("Restarted noncacheable read recounted.");

    // No execute-stage write means no interlock.
    AST_ILK_NONE: assert property (@(posedge core_clk) disable iff (rst)
        (event_code == pes_pkg::EV_ADDR_ILK && agen.exe_wr_valid == 2'h0) |=> (increment == 0))
        else $error("Interlock counted without a write.");

    // Pipe two's execute write to pipe one's index register is an interlock.
    AST_ILK_CROSS: assert property (@(posedge core_clk) disable iff (rst)
        (event_code == pes_pkg::EV_ADDR_ILK && agen.exe_wr_valid[1] && agen.agen_idx_valid[0] &&
         agen.agen_idx_reg[0] == agen.exe_wr_reg[1]) |=> (increment != 0))
        else $error("Cross-pipe interlock missed.");

    // Both address-gen pipes waiting on one execute write add two.
    AST_ILK_BOTH: assert property (@(posedge core_clk) disable iff (rst)
        (event_code == pes_pkg::EV_ADDR_ILK && agen.exe_wr_valid[0] &&
         agen.agen_base_valid == 2'h3 && agen.agen_base_reg[0] == agen.exe_wr_reg[0] &&
         agen.agen_base_reg[1] == agen.exe_wr_reg[0]) |=> (increment == 2))
        else $error("Dual-pipe interlock not counted twice.");

    // A single arithmetic operation with no fault counts one.
    AST_FLT_ONE: assert property (@(posedge core_clk) disable iff (rst)
        (event_code == pes_pkg::EV_FLOAT_OPS && !fpu.excl_fault && fpu.arith_ops == 2'h1 &&
         !fpu.int_mul) |=> (increment == 1))
        else $error("Single float op not counted.");

    // All internal operations plus an integer multiply add four.
    AST_FLT_SUM: assert property (@(posedge core_clk) disable iff (rst)
        (event_code == pes_pkg::EV_FLOAT_OPS && !fpu.excl_fault && fpu.arith_ops == 2'h3 &&
         fpu.int_mul) |=> (increment == 4))
        else $error("Float and integer multiply sum wrong.");

    // Match event zero equals pin zero.
    AST_BP_PIN0: assert property (@(posedge core_clk) disable iff (rst)
        ($past(event_code) == pes_pkg::EV_DBG_MATCH_0)
        |-> (increment == INC_W'(breakpoint_pins[0])))
        else $error("Match zero count differs from pin.");

    // A pipe-one match always reaches its pin.
    AST_BP_U1: assert property (@(posedge core_clk) disable iff (rst)
        bp.match_u[1] |=> breakpoint_pins[1])
        else $error("Pipe-one match lost.");

endmodule // pes_event_select

// ### verif/pes_source_model.sv
// Model of the pipeline, bus unit, float unit and debug comparators that feed the qualifier.
`timescale 1ns/1ps

module pes_source_model (
    input wire logic quiet,
    input wire logic [63:0] raw,
    output logic rd_stall,
    output logic wr_em_stall,
    output pes_pkg::pes_bus_t bus,
    output pes_pkg::pes_agen_t agen,
    output pes_pkg::pes_fpu_t fpu,
    output pes_pkg::pes_bp_t bp
);
    // Shapes a raw word into legal source activity; quiet makes every source idle.
    always_comb begin
        logic [63:0] r;
        r = quiet ? 64'h0 : raw;
        rd_stall = r[0];
        wr_em_stall = r[1];
        // Bus qualifiers only mean something on the first clock of a cycle.
        bus.start = r[2];
        bus.locked = r[2] & r[3];
        bus.write = r[2] & r[4];
        bus.io = r[2] & r[5];
        bus.noncacheable = r[2] & r[6];
        bus.split_cycle_flag = r[2] & r[3] & r[7];
        bus.bus_backoff = r[8] & r[9];
        // Register numbers are kept small so that interlocks occur often.
        agen.exe_wr_valid = r[11:10];
        agen.exe_wr_reg = {{1'b0, r[15:14]}, {1'b0, r[13:12]}};
        agen.agen_base_valid = r[17:16];
        agen.agen_base_reg = {{1'b0, r[21:20]}, {1'b0, r[19:18]}};
        agen.agen_idx_valid = r[23:22];
        agen.agen_idx_reg = {{1'b0, r[27:26]}, {1'b0, r[25:24]}};
        fpu.arith_ops = r[29:28];
        fpu.excl_fault = r[30] & r[31];
        fpu.int_mul = r[32];
        bp.match_u = r[36:33];
        bp.match_v = r[40:37];
        bp.is_code = r[44:41];
        bp.enabled = r[48:45];
    end
endmodule // pes_source_model

// ### verif/pes_event_select_tb.sv
// Self-checking testbench for the event qualifier with a reference model.
`timescale 1ns/1ps

`define CHK(act, expv) begin \
    samples_checked++; \
    if ((act) !== (expv)) begin \
        errors++; \
        $display("unexpected at %0t: got %h expected %h", $time, act, expv); \
    end \
end

module pes_event_select_tb;
    localparam int INC_W = 3;
    logic core_clk;
    logic rst;
    logic quiet;
    logic [7:0] event_code;
    logic [63:0] raw;
    logic rd_stall;
    logic wr_em_stall;
    pes_pkg::pes_bus_t bus;
    pes_pkg::pes_agen_t agen;
    pes_pkg::pes_fpu_t fpu;
    pes_pkg::pes_bp_t bp;
    logic [INC_W-1:0] increment;
    logic [3:0] breakpoint_pins;
    int errors;
    int samples_checked;
    logic mark; // Bench copy of the back-off restart mark.
    logic [7:0] codes [13] = '{8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h21,
                               8'h22, 8'h23, 8'h24, 8'h00, 8'hff};

    pes_event_select #(.INC_W(INC_W)) u_pes_event_select (.core_clk(core_clk), .rst(rst),
        .event_code(event_code), .rd_stall(rd_stall), .wr_em_stall(wr_em_stall), .bus(bus),
        .agen(agen), .fpu(fpu), .bp(bp), .increment(increment),
        .breakpoint_pins(breakpoint_pins));

    pes_source_model u_pes_source_model (.quiet(quiet), .raw(raw), .rd_stall(rd_stall),
        .wr_em_stall(wr_em_stall), .bus(bus), .agen(agen), .fpu(fpu), .bp(bp));

    // Qualified breakpoint matches; pipe two code matches drop when disabled.
    function automatic logic [3:0] pins_of(input pes_pkg::pes_bp_t b);
        return b.match_u | (b.match_v & ~(b.is_code & ~b.enabled));
    endfunction

    // Counts address-gen pipes whose base or index is written in execute.
    function automatic logic [INC_W-1:0] ilk_of(input pes_pkg::pes_agen_t a);
        logic [INC_W-1:0] n;
        n = '0;
        for (int p = 0; p < 2; p++) begin
            logic hit;
            hit = 1'b0;
            for (int e = 0; e < 2; e++) begin
                hit |= a.exe_wr_valid[e] &&
                    ((a.agen_base_valid[p] && a.agen_base_reg[p] == a.exe_wr_reg[e]) ||
                     (a.agen_idx_valid[p] && a.agen_idx_reg[p] == a.exe_wr_reg[e]));
            end
            n += INC_W'(hit);
        end
        return n;
    endfunction

    // Expected increment for the inputs now applied and the restart mark.
    function automatic logic [INC_W-1:0] exp_of(input logic [7:0] c, input logic mk);
        logic cs;
        logic [3:0] p;
        cs = bus.start & ~mk;
        p = pins_of(bp);
        case (c)
            pes_pkg::EV_RD_STALL: return INC_W'(rd_stall);
            pes_pkg::EV_WR_EM_STALL: return INC_W'(wr_em_stall);
            pes_pkg::EV_LOCKED: return (cs & bus.locked & ~bus.write) ?
                INC_W'(bus.split_cycle_flag ? 2 : 1) : '0;
            pes_pkg::EV_IO_CYCLE: return INC_W'(cs & bus.io);
            pes_pkg::EV_NC_READ: return INC_W'(cs & bus.noncacheable & ~bus.write & ~bus.io);
            pes_pkg::EV_ADDR_ILK: return ilk_of(agen);
            pes_pkg::EV_FLOAT_OPS: return (fpu.excl_fault ? '0 : INC_W'(fpu.arith_ops)) +
                INC_W'(fpu.int_mul);
            pes_pkg::EV_DBG_MATCH_0: return INC_W'(p[0]);
            pes_pkg::EV_DBG_MATCH_1: return INC_W'(p[1]);
            default: return '0;
        endcase
    endfunction

    // Checks the outputs for the inputs sampled at this edge, then applies new ones.
    task automatic step(input logic [63:0] r, input logic [7:0] c);
        logic [INC_W-1:0] e;
        @(posedge core_clk);
        #1;
        e = exp_of(event_code, mark);
        mark = bus.bus_backoff | (mark & ~bus.start);
        case (event_code)
            pes_pkg::EV_RD_STALL: `CHK(increment, e)
            pes_pkg::EV_WR_EM_STALL: `CHK(increment, e)
            pes_pkg::EV_LOCKED: `CHK(increment, e)
            pes_pkg::EV_IO_CYCLE: `CHK(increment, e)
            pes_pkg::EV_NC_READ: `CHK(increment, e)
            pes_pkg::EV_ADDR_ILK: `CHK(increment, e)
            pes_pkg::EV_FLOAT_OPS: `CHK(increment, e)
            pes_pkg::EV_DBG_MATCH_0: `CHK(increment, e)
            pes_pkg::EV_DBG_MATCH_1: `CHK(increment, e)
            default: `CHK(increment, e)
        endcase
        `CHK(breakpoint_pins, pins_of(bp))
        raw = r;
        event_code = c;
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Clock of 100 ns period.
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Watchdog so that a stuck run still reaches the report.
    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        close_out();
    end

    // Main sequence: reset, directed corner cases, then random traffic per code.
    initial begin
        rst = 1'b1;
        quiet = 1'b1;
        raw = '0;
        event_code = '0;
        errors = 0;
        samples_checked = 0;
        mark = 1'b0;
        void'($urandom(20020));
        repeat (12) @(posedge core_clk);
        #1 rst = 1'b0;
        quiet = 1'b0;
        // Back-off, restarted I/O cycle, then back-off landing with a start.
        step(64'h300, pes_pkg::EV_IO_CYCLE);
        step(64'h24, pes_pkg::EV_IO_CYCLE);
        step(64'h324, pes_pkg::EV_IO_CYCLE);
        step(64'h24, pes_pkg::EV_IO_CYCLE);
        // Split locked read adds two in one clock; a locked write adds none.
        step(64'h8c, pes_pkg::EV_LOCKED);
        step(64'h1c, pes_pkg::EV_LOCKED);
        step(64'h0, pes_pkg::EV_LOCKED);
        // Both pipes interlock on one register, four float counts, disabled pipe-two code match.
        step(64'h30400, pes_pkg::EV_ADDR_ILK);
        step(64'h1_3000_0000, pes_pkg::EV_FLOAT_OPS);
        step(64'h220_0000_0000, pes_pkg::EV_DBG_MATCH_0);
        step(64'h0, pes_pkg::EV_DBG_MATCH_0);
        foreach (codes[i]) begin
            repeat (150) step({$urandom(), $urandom()}, codes[i]);
            quiet = 1'b1;
            repeat (3) step({$urandom(), $urandom()}, codes[i]);
            quiet = 1'b0;
        end
        // Mid-run reset clears both outputs and the restart mark at once.
        step(64'h2_0000_0301, pes_pkg::EV_RD_STALL);
        step(64'h0, pes_pkg::EV_IO_CYCLE);
        rst = 1'b1;
        #1;
        `CHK(increment, 3'h0)
        `CHK(breakpoint_pins, 4'h0)
        @(posedge core_clk);
        #1 rst = 1'b0;
        mark = 1'b0;
        step(64'h24, pes_pkg::EV_IO_CYCLE);
        step(64'h0, pes_pkg::EV_IO_CYCLE);
        repeat (2) step(64'h0, 8'h00);
        close_out();
    end
endmodule // pes_event_select_tb
